// ==== logic/pmms_top.sv ====
// program space map selection and fetch address decoder
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pmms_top
   import pmms_pkg::*;
#(
   parameter bit SECURE_ROM = 1'b0
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        boot_source_strap,
   input  wire logic        second_irq_pin,
   // core side
   input  wire logic        debug_trap_logic,
   input  wire logic        debug_reset,
   input  wire logic [15:0] fetch_addr,
   output logic             map_ready,
   output pmms_layout_t     layout,
   output pmms_sel_t        fetch_sel,
   output pmms_wait_t       wait_states
);

   // layout from user inputs and trap state
   function automatic pmms_layout_t pick_layout(
      input logic lpb,
      input logic strap,
      input logic trap
   );
      pmms_layout_t res;
      res = LAYOUT_A;
      if (trap)
         res = LAYOUT_A;
      else if (!lpb)
         res = strap ? LAYOUT_B : LAYOUT_A;
      else if (strap || SECURE_ROM)
         res = LAYOUT_D;
      else
         res = LAYOUT_C;
      return res;
   endfunction

   // program space address to one target select
   function automatic pmms_sel_t decode(
      input pmms_layout_t lay,
      input logic [15:0]  a
   );
      pmms_sel_t s;
      s = '0;
      unique case (lay)
         LAYOUT_A:
         begin
            if (a < A_INTERNAL_PROGRAM_ROM_END)
               s.internal_program_rom = 1'b1;
            else if (a < DUAL_PORT_RAM_HI)
               s.rsvd = 1'b1;
            else if (a < DUAL_PORT_RAM_HI_END)
               s.dual_port_ram = 1'b1;
            else
               s.rsvd = 1'b1;
         end
         LAYOUT_B:
         begin
            if (a < DUAL_PORT_RAM_HI)
               s.external_program_rom = 1'b1;
            else if (a < DUAL_PORT_RAM_HI_END)
               s.dual_port_ram = 1'b1;
            else
               s.rsvd = 1'b1;
         end
         LAYOUT_C:
         begin
            if (a < DUAL_PORT_RAM_LO_END)
               s.dual_port_ram = 1'b1;
            else if (a < UPPER_BASE)
               s.rsvd = 1'b1;
            else if (a < C_INTERNAL_PROGRAM_ROM_END)
               s.internal_program_rom = 1'b1;
            else
               s.rsvd = 1'b1;
         end
         LAYOUT_D:
         begin
            if (a < DUAL_PORT_RAM_LO_END)
               s.dual_port_ram = 1'b1;
            else if (a < UPPER_BASE)
               s.rsvd = 1'b1;
            else
               s.external_program_rom = 1'b1;
         end
      endcase
      return s;
   endfunction

   logic       strap_s;
   logic       irq_s;
   logic [1:0] start_cnt_q;
   logic       ready_q;
   logic       capture;
   logic       strap_q;
   logic       irq_q;
   logic       lpb_q;
   pmms_wait_t wait_q;
   logic [31:0] rdata_q;
   logic       wr_acc;
   logic       setup;
   logic       hit;

   // pins pass two flops before use
   pmms_sync2 #(
      .WIDTH (2)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_in   ({boot_source_strap, second_irq_pin}),
      .sync_out ({strap_s, irq_s})
   );

   // count out the synchroniser after reset release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         start_cnt_q <= 2'h0;
      else if (start_cnt_q != CAPTURE_CYC)
         start_cnt_q <= start_cnt_q + 2'h1;
   end

   assign capture = (start_cnt_q == (CAPTURE_CYC - 2'h1));

   // catch strap and irq levels once per pin reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_q <= 1'b0;
         irq_q   <= 1'b0;
         ready_q <= 1'b0;
      end
      else if (capture)
      begin
         strap_q <= strap_s;
         irq_q   <= irq_s;
         ready_q <= 1'b1;
      end
   end

   // apb handshake: zero wait, read data captured in setup
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign hit     = (paddr == AUXF_OFS) || (paddr == WAIT_OFS) ||
                    (paddr == STATUS_OFS && !pwrite);
   assign pslverr = psel && penable && !hit;

   // layout bit; only the pin reset or a software write to AUXF_OFS clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lpb_q <= LPB_RST;
      else if (wr_acc && paddr == AUXF_OFS)
         lpb_q <= pwdata[LPB_POS];
      // debug_reset deliberately not used here
   end

   // wait-state defaults set at capture, then software owned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wait_q <= WAIT_RST;
      else if (capture)
         wait_q <= (strap_s && !irq_s) ? {4{WAIT_SLOW}}
                                       : {4{WAIT_FAST}};
      else if (wr_acc && paddr == WAIT_OFS)
         wait_q <= pwdata[15:0];
   end

   // read mux, registered in the setup phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_q <= 32'h0000_0000;
      else if (setup)
      begin
         rdata_q <= 32'h0000_0000;
         unique case (paddr)
            AUXF_OFS:   rdata_q[LPB_POS] <= lpb_q;
            WAIT_OFS:   rdata_q[15:0]    <= wait_q;
            STATUS_OFS:
            begin
               rdata_q[ST_LAY_POS +: 2] <= layout;
               rdata_q[ST_STR_POS]      <= strap_q;
               rdata_q[ST_IRQ_POS]      <= irq_q;
               rdata_q[ST_TRP_POS]      <= debug_trap_logic;
               rdata_q[ST_SEC_POS]      <= SECURE_ROM;
               rdata_q[ST_RDY_POS]      <= ready_q;
            end
            default:    rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = rdata_q;

   // only the program space is decoded here
   assign layout      = pick_layout(lpb_q, strap_q, debug_trap_logic);
   assign fetch_sel   = decode(layout, fetch_addr);
   assign map_ready   = ready_q;
   assign wait_states = wait_q;

   // checks
   a_trap_forces_a: assert property (@(posedge pclk) disable iff (!presetn)
      debug_trap_logic |-> layout == LAYOUT_A)
      else $error("trap did not force layout a");

   a_trap_restore: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(debug_trap_logic) && $stable(lpb_q) |->
      layout == pick_layout(lpb_q, strap_q, 1'b0))
      else $error("user layout not restored after trap");

   a_sel_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(fetch_sel))
      else $error("fetch select not one-hot");

   a_dual_port_ram_high: assert property (@(posedge pclk) disable iff (!presetn)
      !lpb_q && fetch_addr == 16'hc000 |-> fetch_sel.dual_port_ram)
      else $error("dual-port ram missing at 0xc000");

   a_dual_port_ram_low: assert property (@(posedge pclk) disable iff (!presetn)
      lpb_q && !debug_trap_logic && fetch_addr == 16'h0000
      |-> fetch_sel.dual_port_ram)
      else $error("dual-port ram missing at 0x0");

   a_secure_d: assert property (@(posedge pclk) disable iff (!presetn)
      lpb_q && !debug_trap_logic && (strap_q || SECURE_ROM)
      |-> layout == LAYOUT_D)
      else $error("layout d not chosen");

   a_zero_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ready_q) && !lpb_q && !debug_trap_logic && fetch_addr == 16'h0
      |-> (strap_q ? fetch_sel.external_program_rom : fetch_sel.internal_program_rom))
      else $error("address zero maps to wrong memory");

   a_wait_default: assert property (@(posedge pclk) disable iff (!presetn)
      capture |=> wait_q == (($past(strap_s) && !$past(irq_s))
                 ? {4{WAIT_SLOW}} : {4{WAIT_FAST}}))
      else $error("wait-state default wrong");

   a_bit_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == AUXF_OFS |=> lpb_q == $past(pwdata[LPB_POS]))
      else $error("layout bit write lost");

   a_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
      layout == LAYOUT_A && fetch_addr >= 16'h9000 && fetch_addr < 16'hc000
      |-> fetch_sel.rsvd)
      else $error("reserved region selected memory");

   a_ready_time: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ready_q) |-> $past(start_cnt_q) == 2'h2 ##1 ready_q[*3])
      else $error("strap capture timing wrong");

endmodule
`default_nettype wire

// ==== logic/pmms_pkg.sv ====
// constants and types for the program map selector
package pmms_pkg;

   // apb register byte offsets
   localparam logic [7:0] AUXF_OFS   = 8'h00;
   localparam logic [7:0] WAIT_OFS   = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // field positions
   localparam int LPB_POS    = 14;
   localparam int ST_LAY_POS = 0;
   localparam int ST_STR_POS = 2;
   localparam int ST_IRQ_POS = 3;
   localparam int ST_TRP_POS = 4;
   localparam int ST_SEC_POS = 5;
   localparam int ST_RDY_POS = 6;

   // reset values and the wait-state defaults loaded at capture
   localparam logic       LPB_RST      = 1'b0;
   localparam logic [3:0] WAIT_SLOW    = 4'hf;
   localparam logic [3:0] WAIT_FAST    = 4'h0;
   localparam logic [15:0] WAIT_RST    = 16'h0000;

   // cycles from reset release to strap capture (two sync flops + 1)
   localparam logic [1:0] CAPTURE_CYC  = 2'h3;

   // program space boundaries
   localparam logic [15:0] A_INTERNAL_PROGRAM_ROM_END  = 16'h9000;
   localparam logic [15:0] DUAL_PORT_RAM_HI    = 16'hc000;
   localparam logic [15:0] DUAL_PORT_RAM_HI_END = 16'hd800;
   localparam logic [15:0] DUAL_PORT_RAM_LO_END = 16'h1800;
   localparam logic [15:0] UPPER_BASE  = 16'h4000;
   localparam logic [15:0] C_INTERNAL_PROGRAM_ROM_END  = 16'hd000;

   typedef enum logic [1:0] {
      LAYOUT_A,
      LAYOUT_B,
      LAYOUT_C,
      LAYOUT_D
   } pmms_layout_t;

   // one-hot target selects
   typedef struct packed {
      logic internal_program_rom;
      logic dual_port_ram;
      logic external_program_rom;
      logic rsvd;
   } pmms_sel_t;

   // wait-state fields of the four external segments
   typedef struct packed {
      logic [3:0] external_program_rom;
      logic [3:0] eramhi;
      logic [3:0] io;
      logic [3:0] eramlo;
   } pmms_wait_t;

endpackage

// ==== logic/pmms_sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pmms_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // pin side and synchronised side
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== test/pmms_mem_model.sv ====
// behavioural model of the memories behind the decoder
`timescale 1ns/1ps
`default_nettype none
module pmms_mem_model
   import pmms_pkg::*;
(
   // decoder side
   input  wire logic [15:0] addr,
   input  wire pmms_sel_t   sel,
   // fetched word
   output logic      [15:0] word
);
   // each memory answers with its own pattern; reserved space returns the inverted address
   always_comb
   begin
      if (sel.internal_program_rom) word = 16'h1100 ^ addr;
      else if (sel.dual_port_ram) word = 16'h2200 ^ addr;
      else if (sel.external_program_rom) word = 16'h3300 ^ addr;
      else word = ~addr;
   end
endmodule
`default_nettype wire

// ==== test/pmms_top_tb.sv ====
// self-checking bench for the program map selector
`timescale 1ns/1ps
`default_nettype none
module pmms_top_tb
   import pmms_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic boot_source_strap, second_irq_pin, debug_trap_logic;
   logic debug_reset, map_ready;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] fetch_addr, word;
   pmms_layout_t layout;
   pmms_sel_t    fetch_sel;
   pmms_wait_t   wait_states;
   logic         err;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] probes [14] = '{16'h0000, 16'h17ff, 16'h1800, 16'h3fff,
      16'h4000, 16'h8fff, 16'h9000, 16'hbfff, 16'hc000, 16'hcfff,
      16'hd000, 16'hd7ff, 16'hd800, 16'hffff};

   pmms_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_source_strap(boot_source_strap),
      .second_irq_pin(second_irq_pin), .debug_trap_logic(debug_trap_logic),
      .debug_reset(debug_reset), .fetch_addr(fetch_addr),
      .map_ready(map_ready), .layout(layout), .fetch_sel(fetch_sel),
      .wait_states(wait_states));
   pmms_mem_model mem_u (.addr(fetch_addr), .sel(fetch_sel), .word(word));

   // clock and hang guard
   initial
   begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         fails++;
         tally_and_finish;
      end
   end

   // expected select {internal_program_rom,dual_port_ram,external_program_rom,rsvd} per layout
   function automatic logic [3:0] exp_sel(logic [1:0] l, logic [15:0] a);
      if (l == 2'h0) return a < 16'h9000 ? 4'h8 : a < 16'hc000 ? 4'h1 :
         a < 16'hd800 ? 4'h4 : 4'h1;
      if (l == 2'h1) return a < 16'hc000 ? 4'h2 : a < 16'hd800 ? 4'h4 : 4'h1;
      if (a < 16'h1800) return 4'h4;
      if (a < 16'h4000) return 4'h1;
      if (l == 2'h3) return 4'h2;
      return a < 16'hd000 ? 4'h8 : 4'h1;
   endfunction

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // wait for pready with no count limit; only the bench timeout catches a hang
      do
      begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task rst(input logic s, input logic i);
      int n;
      @(posedge pclk);
      presetn <= 0; boot_source_strap <= s; second_irq_pin <= i;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      n = 0;
      while (map_ready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      #1;
      chk("ready", 1, map_ready);
   endtask

   // walk the boundary probes of one layout, then the boot word
   task walk(input logic [1:0] l);
      #1;
      chk("layout", l, layout);
      foreach (probes[i])
      begin
         @(posedge pclk);
         fetch_addr <= probes[i];
         #1;
         chk("sel", exp_sel(l, probes[i]), fetch_sel);
      end
      @(posedge pclk);
      fetch_addr <= 16'h0000;
      #1;
      chk("word0", l == 0 ? 16'h1100 : l == 1 ? 16'h3300 : 16'h2200, word);
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; boot_source_strap = 0; second_irq_pin = 0;
      debug_trap_logic = 0; debug_reset = 0; fetch_addr = 0;
      rst(0, 0);
      walk(2'h0);
      chk("wait", 16'h0000, wait_states);
      apb(0, AUXF_OFS, 0);
      chk("lpb", 0, rd[14]);
      apb(1, AUXF_OFS, 32'h0000_4000);
      walk(2'h2);
      @(posedge pclk) debug_trap_logic <= 1;
      walk(2'h0);
      @(posedge pclk) debug_trap_logic <= 0;
      @(posedge pclk) debug_reset <= 1;
      @(posedge pclk) debug_reset <= 0;
      walk(2'h2);
      apb(0, 8'h10, 0);
      chk("slverr", 1, err);
      apb(1, WAIT_OFS, 32'h0000_a5c3);
      #1;
      chk("wait", 16'ha5c3, wait_states);
      apb(0, WAIT_OFS, 0);
      chk("wait_rd", 32'h0000_a5c3, rd);
      apb(0, STATUS_OFS, 0);
      chk("status", 32'h0000_0042, rd);
      apb(1, STATUS_OFS, 0);
      chk("st_wr_err", 1, err);
      rst(1, 0);
      walk(2'h1);
      chk("wait", 16'hffff, wait_states);
      apb(1, AUXF_OFS, 32'h0000_4000);
      walk(2'h3);
      rst(1, 1);
      chk("wait", 16'h0000, wait_states);
      tally_and_finish;
   end
endmodule
`default_nettype wire
